// File: hw/dapd_ctrl.sv
// module: power-mode control and output release of the dual converter
`timescale 1ns/1ns

// Overview of operation
// - a low sleep request selects normal conversion and a high one selects the low-power state.
// - in the low-power state the converter core is switched off and no conversions are produced.
// - in the low-power state the parallel output bus is released so other devices can use it.
// - in the low-power state all sample bits of both channels and both over-range flags float.
// - in the low-power state the sample valid strobe floats.
// - in the low-power state both sampling clock inputs present high impedance.
// - a grounded reference setpoint input disables the internal reference.
// - outputs float 10 ns after the sleep request rises and drive again 10 ns after it falls; with the pin synchroniser the code takes 3 to 4 clock cycles for each.
module dapd_ctrl #(
	parameter int unsigned WAKE_CYC = dapd_pkg::WAKE_TIME_CYC
) (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                nrst_i,
	// pins
	input  wire logic                sleep_request_i,
	input  wire logic                reference_setpoint_grounded_i,
	// converter core side
	input  wire dapd_pkg::dapd_out_t core_data_i,
	output logic                     core_enable_o,
	output logic                     internal_ref_enable_o,
	output logic                     clock_input_enable_o,
	output logic                     wake_settled_o,
	// output pins
	output dapd_pkg::dapd_out_t      pin_data_o,
	output logic                     pin_data_oe_o
);
	import dapd_pkg::*;

	// positions inside the pin synchroniser bank
	localparam int unsigned SYNC_SLEEP = 0;
	localparam int unsigned SYNC_REF   = 1;
	localparam int unsigned SYNC_N     = 2;

	logic [SYNC_N-1:0]   pin_raw;
	wire  [SYNC_N-1:0]   pin_sync;
	logic                sleep_sync;
	logic                ref_sync;
	dapd_state_t         state_q;
	dapd_state_t         state_d;
	logic [3:0]          out_cnt_q;
	logic [31:0]         wake_cnt_q;
	logic                wake_done;
	logic [SAMPLE_W-1:0] sample_first_q;
	logic [SAMPLE_W-1:0] sample_second_q;
	logic                over_first_q;
	logic                over_second_q;
	logic                strobe_q;

	// true while the output drivers are being switched on or off
	function automatic logic in_transition(input dapd_state_t s);
		return (s == DAPD_ENTER) || (s == DAPD_LEAVE);
	endfunction

	// true while the output drivers own the shared bus
	function automatic logic drives_bus(input dapd_state_t s);
		return (s == DAPD_ACTIVE) || (s == DAPD_ENTER);
	endfunction

	// true once the release or re-drive delay has run out
	function automatic logic delay_done(input logic [3:0] cnt);
		return cnt >= 4'(OUT_DELAY_CYC - 1);
	endfunction

	assign pin_raw = {reference_setpoint_grounded_i, sleep_request_i};

	// pins come from outside the clock domain; only the second flop is read
	for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
		logic meta_q;
		logic sync_q;

		always_ff @(posedge clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				meta_q <= SYNC_RESET[i];
				sync_q <= SYNC_RESET[i];
			end else begin
				meta_q <= pin_raw[i];
				sync_q <= meta_q;
			end
		end

		assign pin_sync[i] = sync_q;
	end

	assign sleep_sync = pin_sync[SYNC_SLEEP];
	assign ref_sync   = pin_sync[SYNC_REF];

	// level-sensitive mode selection with the output release delay
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			DAPD_ACTIVE: begin
				if (sleep_sync) begin
					state_d = DAPD_ENTER;
				end
			end
			DAPD_ENTER: begin
				// a wake request before the release completes keeps the bus driven
				if (!sleep_sync) begin
					state_d = DAPD_ACTIVE;
				end else if (delay_done(out_cnt_q)) begin
					state_d = DAPD_ASLEEP;
				end
			end
			DAPD_ASLEEP: begin
				if (!sleep_sync) begin
					state_d = DAPD_LEAVE;
				end
			end
			DAPD_LEAVE: begin
				if (sleep_sync) begin
					state_d = DAPD_ASLEEP;
				end else if (delay_done(out_cnt_q)) begin
					state_d = DAPD_ACTIVE;
				end
			end
		endcase
	end

	// reset leaves the bus released until the pin is seen low
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= DAPD_ASLEEP;
		end else begin
			state_q <= state_d;
		end
	end

	// counts the cycles spent switching the output drivers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			out_cnt_q <= OUT_CNT_RESET;
		end else if (state_q != state_d) begin
			out_cnt_q <= OUT_CNT_RESET;
		end else if (in_transition(state_q)) begin
			out_cnt_q <= out_cnt_q + 4'h1;
		end
	end

	// settling indication only; the host still owns its own delay
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wake_cnt_q <= WAKE_CNT_RESET;
		end else if (sleep_sync) begin
			wake_cnt_q <= WAKE_CNT_RESET;
		end else if (!wake_done) begin
			wake_cnt_q <= wake_cnt_q + 32'h1;
		end
	end

	assign wake_done = wake_cnt_q >= 32'(WAKE_CYC);

	// sample registers are cleared while asleep so no stale conversion leaks out
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sample_first_q <= '0;
		end else if (sleep_sync) begin
			sample_first_q <= '0;
		end else begin
			sample_first_q <= core_data_i.sample_bus_first;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sample_second_q <= '0;
		end else if (sleep_sync) begin
			sample_second_q <= '0;
		end else begin
			sample_second_q <= core_data_i.sample_bus_second;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			over_first_q <= 1'b0;
		end else if (sleep_sync) begin
			over_first_q <= 1'b0;
		end else begin
			over_first_q <= core_data_i.over_range_flag_first;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			over_second_q <= 1'b0;
		end else if (sleep_sync) begin
			over_second_q <= 1'b0;
		end else begin
			over_second_q <= core_data_i.over_range_flag_second;
		end
	end

	// a strobe held low while asleep cannot fake a fresh sample on wake-up
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strobe_q <= 1'b0;
		end else if (sleep_sync) begin
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= core_data_i.sample_valid_strobe;
		end
	end

	// core runs only in normal mode
	assign core_enable_o         = !sleep_sync;
	assign clock_input_enable_o  = !sleep_sync;
	// grounded setpoint means the reference nodes are driven from outside
	assign internal_ref_enable_o = !sleep_sync && !ref_sync;
	// unbuffered reference settling is board dependent, so no settled flag there
	assign wake_settled_o        = !sleep_sync && !ref_sync && wake_done;

	assign pin_data_o.sample_bus_first       = sample_first_q;
	assign pin_data_o.sample_bus_second      = sample_second_q;
	assign pin_data_o.over_range_flag_first  = over_first_q;
	assign pin_data_o.over_range_flag_second = over_second_q;
	assign pin_data_o.sample_valid_strobe    = strobe_q;

	// one enable covers samples, flags and strobe
	assign pin_data_oe_o         = drives_bus(state_q);
endmodule // dapd_ctrl

// File: hw/dapd_pkg.sv
// package: constants and carriers for the dual converter power-down control
package dapd_pkg;
	localparam int unsigned SAMPLE_W        = 14;
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned OUT_DELAY_NS    = 10;
	localparam int unsigned OUT_DELAY_CYC   = (OUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WAKE_TIME_MS    = 10;
	localparam int unsigned WAKE_TIME_CYC   = WAKE_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [3:0]  OUT_CNT_RESET   = 4'h0;
	localparam logic [31:0] WAKE_CNT_RESET  = 32'h0;
	// synchroniser values after reset: bit 0 sleep request, bit 1 grounded setpoint
	localparam logic [1:0]  SYNC_RESET      = 2'h1;

	typedef enum logic [1:0] {
		DAPD_ACTIVE,
		DAPD_ENTER,
		DAPD_ASLEEP,
		DAPD_LEAVE
	} dapd_state_t;

	typedef struct packed {
		logic [SAMPLE_W-1:0] sample_bus_first;
		logic [SAMPLE_W-1:0] sample_bus_second;
		logic                over_range_flag_first;
		logic                over_range_flag_second;
		logic                sample_valid_strobe;
	} dapd_out_t;
endpackage

// File: tb/dapd_ctrl_properties.sv
// checker: port properties of the power-down control
`timescale 1ns/1ns
module dapd_ctrl_chk import dapd_pkg::*; (
	input wire logic      clk_i,
	input wire logic      nrst_i,
	input wire logic      sleep_request_i,
	input wire logic      reference_setpoint_grounded_i,
	input wire logic      core_enable_o,
	input wire logic      internal_ref_enable_o,
	input wire logic      clock_input_enable_o,
	input wire logic      wake_settled_o,
	input wire dapd_out_t core_data_i,
	input wire dapd_out_t pin_data_o,
	input wire logic      pin_data_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	property p_core; ##2 core_enable_o != $past(sleep_request_i, 2); endproperty
	a_core: assert property (p_core) else $error("core enable");
	property p_clk; sleep_request_i |=> ##1 !clock_input_enable_o; endproperty
	a_clk: assert property (p_clk) else $error("clock input");
	property p_ref; reference_setpoint_grounded_i |-> ##2 !internal_ref_enable_o; endproperty
	a_ref: assert property (p_ref) else $error("reference");
	property p_off; sleep_request_i[*4] |=> !pin_data_oe_o && pin_data_o == '0; endproperty
	a_off: assert property (p_off) else $error("bus release");
	property p_on; (!sleep_request_i)[*4] |=> pin_data_oe_o; endproperty
	a_on: assert property (p_on) else $error("bus drive");
	property p_settle; reference_setpoint_grounded_i |-> ##2 !wake_settled_o; endproperty
	a_settle: assert property (p_settle) else $error("settled flag");
	property p_data; (!sleep_request_i)[*3] |=> pin_data_o == $past(core_data_i); endproperty
	a_data: assert property (p_data) else $error("sample data");
endmodule // dapd_ctrl_chk

// File: tb/dapd_host.sv
// model: host that drives the sleep pin and captures settled samples
`timescale 1ns/1ns
module dapd_host import dapd_pkg::*; #(parameter int SETTLE = 30) (
	input  wire logic      clk_i,
	input  wire logic      cmd_i,
	input  wire dapd_out_t pin_data_o,
	input  wire logic      pin_data_oe_o,
	output logic           sleep_request_i = 1'b1,
	output dapd_out_t      cap_o
);
	int n = 0;
	always @(posedge clk_i) begin
		sleep_request_i <= cmd_i;
		n <= cmd_i ? 0 : n + 1;
		// a released bus shows a changing pattern, so early capture cannot pass
		if (n > SETTLE) cap_o <= pin_data_oe_o ? pin_data_o : ~cap_o;
	end
endmodule // dapd_host

// File: tb/dapd_ctrl_tb.sv
// testbench: power-down control with a host model
`timescale 1ns/1ns
module dapd_ctrl_tb;
	import dapd_pkg::*;
	logic clk_i = 0, nrst_i = 0, reference_setpoint_grounded_i = 0, cmd_i = 1, sleep_request_i;
	logic core_enable_o, internal_ref_enable_o, clock_input_enable_o, wake_settled_o, pin_data_oe_o;
	dapd_out_t core_data_i = 31'h2BAD1234, pin_data_o, cap_o;
	int mismatches = 0, cmp_count = 0;
	dapd_ctrl #(.WAKE_CYC(20)) i_dut (.*);
	dapd_host i_host (.*);
	initial forever #5 clk_i = ~clk_i;
	task automatic chk(input logic [39:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic t_cycle(input logic g);
		@(posedge clk_i) cmd_i <= 1;
		repeat (6) @(posedge clk_i);
		#1 chk({pin_data_oe_o, core_enable_o, clock_input_enable_o, pin_data_o}, 0);
		@(posedge clk_i) cmd_i <= 0;
		reference_setpoint_grounded_i <= g;
		repeat (40) @(posedge clk_i);
		#1 chk({cap_o, internal_ref_enable_o, wake_settled_o}, {core_data_i, !g, !g});
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		nrst_i <= 1;
		t_cycle(0);
		t_cycle(1);
		complete_run;
	end
endmodule // dapd_ctrl_tb
bind dapd_ctrl dapd_ctrl_chk i_chk (.*);
